// >>> hdl/cap_cmd_defines.svh
// Constants of the capacitive sensor command unit
`ifndef CAP_CMD_DEFINES_SVH
`define CAP_CMD_DEFINES_SVH
`define CMD_RD_LAST    8'h1f
`define CMD_WR_FIRST   8'h20
`define CMD_WR_LAST    8'h3c
`define CMD_CKSUM      8'h90
`define CMD_RAW_S      8'ha2
`define CMD_RAW_SU     8'ha3
`define CMD_RAW_T      8'ha6
`define CMD_SLEEP      8'ha8
`define CMD_START      8'ha9
`define CMD_MEAS       8'haa
`define NVM_WORDS      32
`define NVM_CKSUM_ADDR 5'h1f
`define SENS_CFG_ADDR  5'h03
`define TEMP_CFG_ADDR  5'h04
`define TSCALE_ADDR    5'h05
`define NVM_RST        16'h0000
`define I2C_ADDR_DEF   7'h28
`define HS_ADDR_LO     7'h04
`define HS_ADDR_HI     7'h07
`define ST_POWER       6
`define ST_BUSY        5
`define ST_MODE_LO     3
`define ST_MEMERR      2
`define ST_OVF         1
`define ST_SAT         0
`endif

// >>> hdl/cap_cmd_pkg.sv
// Types of the capacitive sensor command unit
package cap_cmd_pkg;
	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_ADDR = 3'b001,
		L_AACK = 3'b010,
		L_WR   = 3'b011,
		L_WACK = 3'b100,
		L_RD   = 3'b101,
		L_RACK = 3'b110
	} link_state_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_CONV = 2'b01,
		S_CALC = 2'b10,
		S_CORR = 2'b11
	} seq_state_t;
	typedef enum logic [1:0] {
		MODE_SLEEP = 2'b00,
		MODE_CMD   = 2'b01
	} op_mode_t;
	typedef enum logic [1:0] {
		OP_RAW_S = 2'b00,
		OP_RAW_T = 2'b01,
		OP_FULL  = 2'b10
	} meas_op_t;
	typedef enum logic [1:0] {
		K_AZS = 2'b00,
		K_SM  = 2'b01,
		K_AZT = 2'b10,
		K_TM  = 2'b11
	} conv_kind_t;
endpackage

// >>> hdl/sync2.sv
// Two-flop synchroniser for pin inputs
module sync2 #(
	parameter int          W   = 2,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_w
		$error("sync2 width must be at least one");
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_r <= RST;
			q      <= RST;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// >>> hdl/i2c_link.sv
// Byte level serial slave on oversampled clock and data lines
`include "cap_cmd_defines.svh"
module i2c_link
	import cap_cmd_pkg::*;
#(
	parameter logic [6:0] ADDR = `I2C_ADDR_DEF
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [7:0] tx_byte,
	output logic            sda_oe,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            tx_next,
	output logic            frame_start,
	output logic            frame_stop
);
	link_state_t st_r;
	logic        scl_q;
	logic        sda_q;
	logic [7:0]  sh_r;
	logic [7:0]  txsh_r;
	logic [2:0]  cnt_r;
	logic        rw_r;
	logic        nack_r;
	logic        bit_seen_r;

	if (ADDR >= `HS_ADDR_LO && ADDR <= `HS_ADDR_HI) begin : g_bad_addr
		$error("slave address reserved for high speed master codes");
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r        <= L_IDLE;
			scl_q       <= 1'b1;
			sda_q       <= 1'b1;
			sh_r        <= 8'h00;
			txsh_r      <= 8'h00;
			cnt_r       <= 3'h0;
			rw_r        <= 1'b0;
			nack_r      <= 1'b0;
			bit_seen_r  <= 1'b0;
			sda_oe      <= 1'b0;
			rx_valid    <= 1'b0;
			rx_byte     <= 8'h00;
			tx_next     <= 1'b0;
			frame_start <= 1'b0;
			frame_stop  <= 1'b0;
		end else begin
			rx_valid    <= 1'b0;
			tx_next     <= 1'b0;
			frame_start <= 1'b0;
			frame_stop  <= 1'b0;
			scl_q       <= scl;
			sda_q       <= sda;
			if (scl && scl_q && sda_q && !sda) begin
				// Start or repeated start
				st_r        <= L_ADDR;
				cnt_r       <= 3'h0;
				sda_oe      <= 1'b0;
				frame_start <= 1'b1;
				bit_seen_r  <= 1'b0;
			end else if (scl && scl_q && !sda_q && sda) begin
				st_r       <= L_IDLE;
				sda_oe     <= 1'b0;
				frame_stop <= 1'b1;
			end else if (scl && !scl_q) begin
				bit_seen_r <= 1'b1;
				if (st_r == L_ADDR || st_r == L_WR) begin
					sh_r <= {sh_r[6:0], sda};
				end
				if (st_r == L_RACK) begin
					nack_r <= sda;
				end
			end else if (!scl && scl_q) begin
				unique case (st_r)
					L_ADDR: begin
						// The fall that ends the start is not a bit
						if (bit_seen_r) begin
							cnt_r <= cnt_r + 3'h1;
						end
						if (bit_seen_r && cnt_r == 3'h7) begin
							if (sh_r[7:1] == ADDR) begin
								rw_r   <= sh_r[0];
								sda_oe <= 1'b1;
								st_r   <= L_AACK;
							end else begin
								st_r <= L_IDLE;
							end
						end
					end
					L_WR: begin
						cnt_r <= cnt_r + 3'h1;
						if (cnt_r == 3'h7) begin
							rx_valid <= 1'b1;
							rx_byte  <= sh_r;
							sda_oe   <= 1'b1;
							st_r     <= L_WACK;
						end
					end
					L_AACK, L_RACK: begin
						cnt_r <= 3'h0;
						if (st_r == L_AACK && !rw_r) begin
							sda_oe <= 1'b0;
							st_r   <= L_WR;
						end else if (st_r == L_RACK && nack_r) begin
							sda_oe <= 1'b0;
							st_r   <= L_IDLE;
						end else begin
							txsh_r  <= tx_byte;
							sda_oe  <= ~tx_byte[7];
							tx_next <= 1'b1;
							st_r    <= L_RD;
						end
					end
					L_WACK: begin
						cnt_r  <= 3'h0;
						sda_oe <= 1'b0;
						st_r   <= L_WR;
					end
					L_RD: begin
						cnt_r  <= cnt_r + 3'h1;
						txsh_r <= {txsh_r[6:0], 1'b0};
						if (cnt_r == 3'h7) begin
							sda_oe <= 1'b0;
							st_r   <= L_RACK;
						end else begin
							sda_oe <= ~txsh_r[6];
						end
					end
					default: begin
						st_r <= L_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// >>> hdl/cap_cmd_unit.sv
// Command decoder, measurement sequencer and result formatter
// Contract
// - Results leave as 24-bit words, two of them for AAh
// - Raw right-justified, corrected left-justified at bit 23
// - Corrected results: unsigned fraction, bit 23 unit
// - Raw results: signed two's-complement fraction
// - Sensor raw is half of sensor minus zero
// - Temperature raw is half of temperature minus zero
// - Zero conversion swaps inputs, same setup
// - Command AAh runs four conversions then correction
// - Corrected sensor word first, then temperature
// - Commands 00h-1Fh return one memory word
// - Commands 20h-3Ch write data to command minus 20h
// - Locked memory ignores write commands
// - Command 90h stores memory checksum in memory
// - A2h loads stored sensor setup, raw conversion
// - A3h raw sensor conversion with given setup
// - A6h loads temperature setup, raw conversion
// - Raw commands also run sensor zero conversion
// - A8h enters sleep, refused while asleep
// - Sleep entry replies with status byte only
// - A9h first after power-up enters command mode
// - Only A8h and A9h depend on mode; other defined commands accepted in any mode
// - Busy blocks new commands and hides data
// - Status bits 4:3 report operating mode
`include "cap_cmd_defines.svh"
module cap_cmd_unit
	import cap_cmd_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR = `I2C_ADDR_DEF
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        nvm_lock,
	output logic             conv_start,
	output conv_kind_t       conv_kind,
	output logic             conv_swap,
	output logic [15:0]      conv_setup,
	output logic [15:0]      conv_scale,
	input  wire logic        conv_done,
	input  wire logic [23:0] conv_data,
	input  wire logic        conv_ovf,
	output logic             corr_start,
	output logic [23:0]      corr_sensor_raw,
	output logic [23:0]      corr_temp_raw,
	input  wire logic        corr_done,
	input  wire logic [23:0] corr_sensor,
	input  wire logic [23:0] corr_temp,
	input  wire logic        corr_sat,
	output logic             busy,
	output op_mode_t         op_mode
);
	logic [1:0]  pins_s;
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        tx_next;
	logic        frame_start;
	logic        frame_stop;
	logic [7:0]  tx_byte;
	logic [7:0]  cmd_r;
	logic [15:0] dat_r;
	logic [1:0]  wr_cnt_r;
	logic [2:0]  rd_idx_r;
	logic        first_r;
	logic [15:0] mem_r [`NVM_WORDS];
	logic [15:0] shadow_sens_r;
	logic [15:0] shadow_temp_r;
	seq_state_t  state_r;
	meas_op_t    op_r;
	conv_kind_t  step_r;
	conv_kind_t  step_nxt;
	logic        last;
	logic [23:0] res_r [4];
	logic [47:0] out_buf_r;
	logic [2:0]  out_len_r;
	logic        ovf_r;
	logic        sat_r;
	logic        go;
	logic        is_meas;
	logic [15:0] sens_val;
	logic        mem_we;
	logic [4:0]  mem_wa;
	logic [15:0] mem_wd;
	logic [15:0] cksum;
	logic [7:0]  status;
	logic [23:0] raw_s;
	logic [23:0] raw_t;

	function automatic logic is_wr(input logic [7:0] c);
		return c >= `CMD_WR_FIRST && c <= `CMD_WR_LAST;
	endfunction

	// Half of the difference, one bit wider to avoid overflow
	function automatic logic [23:0] half_diff(input logic [23:0] m, input logic [23:0] z);
		logic [24:0] d;
		d = {m[23], m} - {z[23], z};
		return d[24:1];
	endfunction

	function automatic logic allowed(input logic [7:0] c, input op_mode_t m,
			input logic first, input logic [1:0] n);
		logic need;
		logic ok;
		need = is_wr(c) || c == `CMD_RAW_S || c == `CMD_RAW_SU || c == `CMD_RAW_T;
		if (c == `CMD_SLEEP) begin
			ok = (m == MODE_CMD);
		end else if (c == `CMD_START) begin
			ok = (m == MODE_CMD) || first;
		end else begin
			ok = c <= `CMD_WR_LAST || c == `CMD_CKSUM || c == `CMD_RAW_S
				|| c == `CMD_RAW_SU || c == `CMD_RAW_T || c == `CMD_MEAS;
		end
		return ok && (!need || n >= 2'd2);
	endfunction

	sync2 #(
		.W   (2),
		.RST (2'b11)
	) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.d     ({scl_i, sda_i}),
		.q     (pins_s)
	);

	i2c_link #(
		.ADDR (I2C_ADDR)
	) u_link (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.scl         (pins_s[1]),
		.sda         (pins_s[0]),
		.tx_byte     (tx_byte),
		.sda_oe      (sda_oe),
		.rx_valid    (rx_valid),
		.rx_byte     (rx_byte),
		.tx_next     (tx_next),
		.frame_start (frame_start),
		.frame_stop  (frame_stop)
	);

	// Open drain: only ever pulls low
	always_ff @(posedge mclk) begin
		sda_o <= 1'b0;
	end

	// Command is decided at the stop; refused ones leave no trace
	assign go = frame_stop && wr_cnt_r != 2'd0 && !busy
		&& allowed(cmd_r, op_mode, first_r, wr_cnt_r - 2'd1);
	assign is_meas = cmd_r == `CMD_RAW_S || cmd_r == `CMD_RAW_SU
		|| cmd_r == `CMD_RAW_T || cmd_r == `CMD_MEAS;
	assign sens_val = (cmd_r == `CMD_RAW_SU) ? dat_r : mem_r[`SENS_CFG_ADDR];

	// Write side of the link
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmd_r    <= 8'h00;
			dat_r    <= 16'h0000;
			wr_cnt_r <= 2'd0;
		end else if (frame_start) begin
			wr_cnt_r <= 2'd0;
		end else if (rx_valid) begin
			// Extra bytes of a padded frame are dropped
			if (wr_cnt_r != 2'd3) begin
				wr_cnt_r <= wr_cnt_r + 2'd1;
			end
			if (wr_cnt_r == 2'd0) begin
				cmd_r <= rx_byte;
			end else if (wr_cnt_r != 2'd3) begin
				dat_r <= {dat_r[7:0], rx_byte};
			end
		end
	end

	// Operating mode
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			op_mode <= MODE_SLEEP;
			first_r <= 1'b1;
		end else if (go) begin
			first_r <= 1'b0;
			if (cmd_r == `CMD_SLEEP) begin
				op_mode <= MODE_SLEEP;
			end else if (cmd_r == `CMD_START) begin
				op_mode <= MODE_CMD;
			end
		end
	end

	// Memory write port
	always_comb begin
		cksum = 16'h0000;
		for (int i = 0; i < `NVM_WORDS - 1; i++) begin
			cksum = cksum + mem_r[i];
		end
	end

	assign mem_we = go && ((is_wr(cmd_r) && !nvm_lock) || cmd_r == `CMD_CKSUM);
	assign mem_wa = is_wr(cmd_r) ? 5'(cmd_r - `CMD_WR_FIRST) : `NVM_CKSUM_ADDR;
	assign mem_wd = is_wr(cmd_r) ? dat_r : cksum;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < `NVM_WORDS; i++) begin
				mem_r[i] <= `NVM_RST;
			end
		end else if (mem_we) begin
			mem_r[mem_wa] <= mem_wd;
		end
	end

	// Conversion order: zero sensor, sensor, zero temp, temp
	assign step_nxt = (op_r == OP_RAW_T && step_r == K_AZS) ? K_AZT
		: conv_kind_t'(step_r + 2'd1);
	assign last = (op_r == OP_RAW_S && step_r == K_SM) || step_r == K_TM;

	// Measurement sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r         <= S_IDLE;
			busy            <= 1'b0;
			op_r            <= OP_RAW_S;
			step_r          <= K_AZS;
			shadow_sens_r   <= `NVM_RST;
			shadow_temp_r   <= `NVM_RST;
			conv_start      <= 1'b0;
			conv_kind       <= K_AZS;
			conv_swap       <= 1'b0;
			conv_setup      <= 16'h0000;
			conv_scale      <= 16'h0000;
			corr_start      <= 1'b0;
			corr_sensor_raw <= 24'h000000;
			corr_temp_raw   <= 24'h000000;
		end else begin
			conv_start <= 1'b0;
			corr_start <= 1'b0;
			unique case (state_r)
				S_IDLE: begin
					if (go && is_meas) begin
						busy          <= 1'b1;
						state_r       <= S_CONV;
						step_r        <= K_AZS;
						op_r          <= (cmd_r == `CMD_MEAS) ? OP_FULL
							: (cmd_r == `CMD_RAW_T) ? OP_RAW_T : OP_RAW_S;
						shadow_sens_r <= sens_val;
						conv_start    <= 1'b1;
						conv_kind     <= K_AZS;
						conv_swap     <= 1'b1;
						conv_setup    <= sens_val;
						if (cmd_r == `CMD_RAW_T || cmd_r == `CMD_MEAS) begin
							shadow_temp_r <= mem_r[`TEMP_CFG_ADDR];
							conv_scale    <= mem_r[`TSCALE_ADDR];
						end
					end
				end
				S_CONV: begin
					if (conv_done) begin
						if (last) begin
							state_r <= S_CALC;
						end else begin
							step_r     <= step_nxt;
							conv_start <= 1'b1;
							conv_kind  <= step_nxt;
							conv_swap  <= ~step_nxt[0];
							conv_setup <= step_nxt[1] ? shadow_temp_r : shadow_sens_r;
						end
					end
				end
				S_CALC: begin
					if (op_r == OP_FULL) begin
						corr_start      <= 1'b1;
						corr_sensor_raw <= raw_s;
						corr_temp_raw   <= raw_t;
						state_r         <= S_CORR;
					end else begin
						busy    <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				S_CORR: begin
					if (corr_done) begin
						busy    <= 1'b0;
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

	assign raw_s = half_diff(res_r[K_SM], res_r[K_AZS]);
	assign raw_t = half_diff(res_r[K_TM], res_r[K_AZT]);

	// Results and flags of the last command
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				res_r[i] <= 24'h000000;
			end
			out_buf_r <= 48'h000000000000;
			out_len_r <= 3'd0;
			ovf_r     <= 1'b0;
			sat_r     <= 1'b0;
		end else begin
			if (go) begin
				ovf_r     <= 1'b0;
				sat_r     <= 1'b0;
				out_len_r <= 3'd0;
				if (cmd_r <= `CMD_RD_LAST) begin
					out_buf_r <= {mem_r[cmd_r[4:0]], 32'h00000000};
					out_len_r <= 3'd2;
				end
			end
			if (state_r == S_CONV && conv_done) begin
				res_r[step_r] <= conv_data;
				if (step_r == K_SM && conv_ovf) begin
					ovf_r <= 1'b1;
				end
			end
			if (state_r == S_CALC && op_r != OP_FULL) begin
				// Raw word fills the top 24 bits of the buffer, low bit at bit 24
				out_buf_r <= {(op_r == OP_RAW_T) ? raw_t : raw_s, 24'h000000};
				out_len_r <= 3'd3;
			end
			if (state_r == S_CORR && corr_done) begin
				out_buf_r <= {corr_sensor, corr_temp};
				out_len_r <= 3'd6;
				sat_r     <= corr_sat;
			end
		end
	end

	// Status byte
	always_comb begin
		status                              = 8'h00;
		status[`ST_POWER]                   = 1'b1;
		status[`ST_BUSY]                    = busy;
		status[`ST_MODE_LO + 1:`ST_MODE_LO] = op_mode;
		status[`ST_MEMERR]                  = 1'b0;
		status[`ST_OVF]                     = ovf_r;
		status[`ST_SAT]                     = sat_r;
	end

	// Read side: status, then result bytes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_idx_r <= 3'd0;
		end else if (frame_start) begin
			rd_idx_r <= 3'd0;
		end else if (tx_next && rd_idx_r != 3'd7) begin
			rd_idx_r <= rd_idx_r + 3'd1;
		end
	end

	always_comb begin
		if (rd_idx_r == 3'd0 || busy) begin
			tx_byte = status;
		end else if (rd_idx_r > out_len_r) begin
			tx_byte = 8'h00;
		end else begin
			tx_byte = out_buf_r[{3'(3'd6 - rd_idx_r), 3'b000} +: 8];
		end
	end
endmodule

// >>> testbench/cap_cmd_unit_asserts.sv
// Port checks for the capacitive sensor command unit
module cap_cmd_unit_asserts
	import cap_cmd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic conv_start,
	input conv_kind_t conv_kind,
	input wire logic conv_swap,
	input wire logic conv_done,
	input wire logic corr_start,
	input wire logic corr_done,
	input wire logic busy,
	input op_mode_t  op_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_zero_swap: assert property (conv_start |-> conv_swap == !conv_kind[0])
		else $error("swap flag does not match conversion kind");
	a_conv_busy: assert property (conv_start |-> busy)
		else $error("conversion started while not busy");
	a_first_zero: assert property ($rose(busy) |-> conv_start && conv_kind == K_AZS)
		else $error("measurement did not begin with sensor zero conversion");
	a_zero_next: assert property (conv_done && busy && conv_kind == K_AZS |=> conv_start)
		else $error("no conversion followed the sensor zero conversion");
	a_sensor_order: assert property (conv_start && conv_kind == K_SM
		|-> $past(conv_kind) == K_AZS)
		else $error("sensor conversion not preceded by its zero conversion");
	a_temp_order: assert property (conv_start && conv_kind == K_TM
		|-> $past(conv_kind) == K_AZT)
		else $error("temperature conversion not preceded by its zero conversion");
	a_corr_after: assert property (corr_start |-> busy && conv_kind == K_TM)
		else $error("correction started before temperature conversion");
	a_busy_end: assert property (corr_done && busy |-> ##[1:2] !busy)
		else $error("busy stayed high after correction finished");
	a_mode_code: assert property (op_mode[1] == 1'b0)
		else $error("reserved mode code reported");
	a_mode_idle: assert property ($changed(op_mode) |-> !$past(busy))
		else $error("mode changed during a measurement");
endmodule
bind cap_cmd_unit cap_cmd_unit_asserts u_cap_cmd_unit_asserts (
	.mclk(mclk), .rst_n(rst_n), .conv_start(conv_start), .conv_kind(conv_kind),
	.conv_swap(conv_swap), .conv_done(conv_done), .corr_start(corr_start),
	.corr_done(corr_done), .busy(busy), .op_mode(op_mode)
);

// >>> testbench/conv_model.sv
// Converter and correction engine model answering the command unit
module conv_model
	import cap_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        clr,
	input  wire logic        conv_start,
	input  conv_kind_t       conv_kind,
	input  wire logic [15:0] conv_setup,
	input  wire logic        corr_start,
	output logic             conv_done,
	output logic [23:0]      conv_data,
	output logic             corr_done,
	output logic [23:0]      corr_sensor,
	output logic [23:0]      corr_temp,
	output logic [7:0]       kinds,
	output logic [15:0]      sens_setup
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  cnt;
	logic        corr_pend;
	logic [23:0] res;
	always_comb begin
		case (conv_kind)
			K_AZS: res = 24'h000100;
			K_SM: res = 24'h000500;
			K_AZT: res = 24'h000040;
			default: res = 24'hfffff0;
		endcase
	end
	// Stale results are inverted outside the answer cycle
	assign conv_data = conv_done ? res : ~res;
	assign corr_sensor = corr_done ? 24'habcdef : 24'h543210;
	assign corr_temp = corr_done ? 24'h123456 : 24'hedcba9;
	always_ff @(posedge mclk) begin
		conv_done <= 1'b0;
		corr_done <= 1'b0;
		if (clr) begin
			cnt <= 8'h00;
			kinds <= 8'h00;
		end else if (conv_start || corr_start) begin
			cnt <= 8'hc8;
			corr_pend <= corr_start;
			kinds <= conv_start ? {kinds[5:0], conv_kind} : kinds;
		end else if (cnt == 8'h01) begin
			cnt <= 8'h00;
			conv_done <= !corr_pend;
			corr_done <= corr_pend;
		end else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	always_ff @(posedge mclk) begin
		if (conv_start && conv_kind == K_SM)
			sens_setup <= conv_setup;
	end
endmodule

// >>> testbench/tb_cap_cmd_unit.sv
// Self-checking bench for the capacitive sensor command unit
`include "cap_cmd_defines.svh"
module tb_cap_cmd_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic                     mclk, rst_n, scl_i, sda_h, nvm_lock, clr, ph, a, sda_o;
	logic                     sda_oe, conv_start, conv_done, corr_start, corr_done, busy;
	cap_cmd_pkg::conv_kind_t  conv_kind;
	cap_cmd_pkg::op_mode_t    op_mode;
	logic [15:0]              conv_setup, sens_setup, conv_scale;
	logic [23:0]              conv_data, corr_sensor, corr_temp, s_raw, t_raw;
	logic [7:0]               kinds, q;
	logic [7:0]               rb [0:6];
	int                       mismatches, n_compared;
	wire                      sda_i = sda_h & ~sda_oe;
	always #5 mclk = ~mclk;
	cap_cmd_unit u_cap_cmd_unit (
		.mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
		.nvm_lock(nvm_lock), .conv_start(conv_start), .conv_kind(conv_kind), .conv_swap(),
		.conv_setup(conv_setup), .conv_scale(conv_scale), .conv_done(conv_done),
		.conv_data(conv_data), .conv_ovf(1'b0), .corr_start(corr_start), .corr_sensor_raw(s_raw),
		.corr_temp_raw(t_raw), .corr_done(corr_done), .corr_sensor(corr_sensor),
		.corr_temp(corr_temp), .corr_sat(1'b0), .busy(busy), .op_mode(op_mode)
	);
	conv_model u_conv_model (
		.mclk(mclk), .clr(clr), .conv_start(conv_start), .conv_kind(conv_kind),
		.conv_setup(conv_setup), .corr_start(corr_start), .conv_done(conv_done),
		.conv_data(conv_data), .corr_done(corr_done), .corr_sensor(corr_sensor),
		.corr_temp(corr_temp), .kinds(kinds), .sens_setup(sens_setup)
	);
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One serial bit, period alternating 12 and 13 cycles
	task automatic clk_bit(input logic b);
		cyc(2);
		sda_h <= b;
		cyc(4 + ph);
		ph = ~ph;
		scl_i <= 1'b1;
		cyc(3);
		a = sda_i;
		cyc(3);
		scl_i <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic b);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i]);
			q[i] = a;
		end
		clk_bit(b);
	endtask
	task automatic start();
		cyc(6);
		sda_h <= 1'b0;
		cyc(6);
		scl_i <= 1'b0;
	endtask
	task automatic stop();
		cyc(2);
		sda_h <= 1'b0;
		cyc(4);
		scl_i <= 1'b1;
		cyc(6);
		sda_h <= 1'b1;
		cyc(8);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
		start();
		xfer({`I2C_ADDR_DEF, 1'b0}, 1'b1);
		check(24'(a), 24'h0);
		xfer(c, 1'b1);
		if (n > 0)
			xfer(d[15:8], 1'b1);
		if (n > 1)
			xfer(d[7:0], 1'b1);
		stop();
	endtask
	task automatic rd(input int n);
		start();
		xfer({`I2C_ADDR_DEF, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1);
			rb[i] = q;
		end
		stop();
	endtask
	task automatic rdmem(input logic [7:0] c, input logic [15:0] exp);
		wr(c, 16'h0000, 0);
		rd(3);
		check(24'({rb[1], rb[2]}), 24'(exp));
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 3000) begin
			cyc(1);
			k++;
		end
		if (k >= 3000) begin
			mismatches++;
			final_report();
		end
	endtask
	task automatic meas(input logic [7:0] c, input logic [15:0] d, input int n,
			input logic [7:0] k, input int nb);
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		wr(c, d, n);
		rd(1);
		check(24'(rb[0][5]), 24'h1);
		if (c == `CMD_MEAS)
			wr(8'h25, 16'h0000, 2);
		wait_idle();
		check(24'(kinds), 24'(k));
		rd(nb);
		$display("end of measurement test %h", c);
	endtask
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		scl_i = 1'b1;
		sda_h = 1'b1;
		nvm_lock = 1'b0;
		clr = 1'b1;
		ph = 1'b0;
		mismatches = 0;
		n_compared = 0;
		cyc(2);
		rst_n <= 1'b1;
		clr <= 1'b0;
		cyc(4);
		rd(1);
		check(24'(rb[0]), 24'h40);
		check(24'(sda_o), 24'h0);
		wr(`CMD_START, 16'h0000, 0);
		rd(1);
		check(24'(rb[0]), 24'h48);
		check(24'(op_mode), 24'h1);
		$display("end of mode entry test");
		wr(8'h23, 16'h5a5a, 2);
		wr(8'h25, 16'h1234, 2);
		nvm_lock <= 1'b1;
		wr(8'h25, 16'hffff, 2);
		nvm_lock <= 1'b0;
		wr(8'h26, 16'h7777, 1);
		rdmem(8'h03, 16'h5a5a);
		rdmem(8'h05, 16'h1234);
		rdmem(8'h06, 16'h0000);
		wr(`CMD_CKSUM, 16'h0000, 0);
		rdmem(8'h1f, 16'h6c8e);
		$display("end of memory test");
		meas(`CMD_RAW_S, 16'h0000, 2, 8'h01, 4);
		check(24'(sens_setup), 24'h5a5a);
		check({rb[1], rb[2], rb[3]}, 24'h000200);
		meas(`CMD_RAW_SU, 16'h0f0f, 2, 8'h01, 4);
		check(24'(sens_setup), 24'h0f0f);
		meas(`CMD_RAW_T, 16'h0000, 2, 8'h0b, 4);
		check({rb[1], rb[2], rb[3]}, 24'hffffd8);
		check(24'(conv_scale), 24'h1234);
		meas(`CMD_MEAS, 16'h0000, 0, 8'h1b, 7);
		check({rb[1], rb[2], rb[3]}, 24'habcdef);
		check({rb[4], rb[5], rb[6]}, 24'h123456);
		check(s_raw, 24'h000200);
		check(t_raw, 24'hffffd8);
		rdmem(8'h05, 16'h1234);
		wr(`CMD_SLEEP, 16'h0000, 0);
		rd(2);
		check(24'({rb[0], rb[1]}), 24'h4000);
		check(24'(op_mode), 24'h0);
		wr(`CMD_START, 16'h0000, 0);
		check(24'(op_mode), 24'h0);
		$display("end of sleep test");
		final_report();
	end
endmodule
